// >>> include/ecs_pkg.sv
/*
 * constants, field layouts and enumerations of the encoder and
 * edge-separation counter; assumes one 25 mhz system clock.
 */
// Overview of operation
// - nothing counts until software arms the unit
// - x1: up on a rise, down on a fall
// - x2: step on both a edges, phase sets direction
// - x4: step on every a and b edge
// - index high in chosen phase loads reload value
// - count step applied before index reload
// - reload each clock while index high in phase, then normal counting
// - two-pulse: a rise adds, b rise subtracts
// - buffered position captures count on sample edge
// - captures never clear count, values are streamed
// - start edge begins source counting, later starts ignored
// - gate edge stops counting and, outside sampled mode, pushes count
// - start and gate polarity each selectable
// - single mode ignores everything after one result
// - implicit mode restarts at next gate edge
// - sampled mode stores result only on sample edge
// - sample edge without completed pair flags overrun
package ecs_pkg;
    localparam int CW = 32;
    localparam int AW = 3;
    localparam int DW = 32;
    localparam logic [CW-1:0] CNT_ONE = 32'h1;
    localparam logic [CW-1:0] CNT_ZERO = 32'h0;

    // word addresses of the register port
    localparam logic [AW-1:0] REG_CTRL = 3'h0;
    localparam logic [AW-1:0] REG_RELOAD = 3'h1;
    localparam logic [AW-1:0] REG_COUNT = 3'h2;
    localparam logic [AW-1:0] REG_DATA = 3'h3;
    localparam logic [AW-1:0] REG_STATUS = 3'h4;
    localparam logic [AW-1:0] REG_MASK = 3'h5;
    localparam logic [AW-1:0] REG_STATE = 3'h6;

    // control register fields
    localparam int CTL_W = 13;
    localparam int CTL_ARM = 0;
    localparam int CTL_MODE = 1;
    localparam int CTL_DEC = 4;
    localparam int CTL_PHASE = 6;
    localparam int CTL_ZEN = 8;
    localparam int CTL_SMP_FALL = 9;
    localparam int CTL_AUX_FALL = 10;
    localparam int CTL_GATE_FALL = 11;
    localparam int CTL_SRC_FALL = 12;
    localparam logic [CTL_W-1:0] CTL_RST = 13'h0;

    // status / mask bits
    localparam int SW = 3;
    localparam int ST_DATA = 0;
    localparam int ST_OVR = 1;
    localparam int ST_OFLOW = 2;

    // synchroniser input lanes
    localparam int NIN = 7;
    localparam int IN_A = 0;
    localparam int IN_B = 1;
    localparam int IN_Z = 2;
    localparam int IN_GATE = 3;
    localparam int IN_AUX = 4;
    localparam int IN_SRC = 5;
    localparam int IN_SMP = 6;

    // result fifo
    localparam int FDEPTH = 4;
    localparam int FAW = 2;
    localparam logic [FAW:0] FIFO_FULL = 3'h4;
    localparam logic [FAW:0] FIFO_ONE = 3'h1;
    localparam logic [FAW-1:0] PTR_ONE = 2'h1;

    typedef enum logic [2:0] {
        MODE_POS_DEMAND = 3'h0,
        MODE_POS_BUF = 3'h1,
        MODE_SEP_SINGLE = 3'h2,
        MODE_SEP_IMPL = 3'h3,
        MODE_SEP_SMP = 3'h4
    } ecs_mode_t;

    typedef enum logic [1:0] {
        DEC_X1 = 2'h0,
        DEC_X2 = 2'h1,
        DEC_X4 = 2'h2,
        DEC_TWO = 2'h3
    } ecs_dec_t;

    typedef enum logic [5:0] {
        SEP_IDLE = 6'h01,
        SEP_WAIT_START = 6'h02,
        SEP_COUNT = 6'h04,
        SEP_HOLD = 6'h08,
        SEP_WAIT_GATE = 6'h10,
        SEP_DONE = 6'h20
    } ecs_sep_t;
endpackage : ecs_pkg

// >>> hdl/ecs_in_sync.sv
/*
 * two-flop synchroniser with edge detect per input lane;
 * assumes asynchronous pins and one system clock.
 */
`timescale 1ns/1ps
module ecs_in_sync #(
    parameter int W = 7
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_lvl,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_lane
            // only sync_reg reads meta_reg
            always_ff @(posedge i_sys_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end
                else
                begin
                    meta_reg[gi] <= i_pin[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
            assign o_lvl[gi] = sync_reg[gi];
            assign o_rise[gi] = sync_reg[gi] & ~prev_reg[gi];
            assign o_fall[gi] = ~sync_reg[gi] & prev_reg[gi];
        end
    endgenerate
endmodule : ecs_in_sync

// >>> hdl/ecs_counter.sv
/*
 * encoder position and two-signal edge-separation counter with
 * result fifo, stream output and interrupt; assumes a plain
 * register port on the 25 mhz system clock and asynchronous pins.
 */
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module ecs_counter (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [ecs_pkg::AW-1:0] i_addr,
    input wire logic [ecs_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ecs_pkg::DW-1:0] o_rdata,
    input wire logic i_enc_a,
    input wire logic i_enc_b,
    input wire logic i_enc_z,
    input wire logic i_gate,
    input wire logic i_aux,
    input wire logic i_src,
    input wire logic i_smp,
    input wire logic i_stm_ready,
    output logic o_stm_valid,
    output logic [ecs_pkg::CW-1:0] o_stm_data,
    output logic o_irq
);
    logic [ecs_pkg::NIN-1:0] lvl;
    logic [ecs_pkg::NIN-1:0] rise;
    logic [ecs_pkg::NIN-1:0] fall;

    ecs_in_sync #(
        .W(ecs_pkg::NIN)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin({i_smp, i_src, i_aux, i_gate, i_enc_z, i_enc_b, i_enc_a}),
        .o_lvl(lvl),
        .o_rise(rise),
        .o_fall(fall)
    );

    logic [ecs_pkg::CTL_W-1:0] ctrl_reg;
    logic [ecs_pkg::CW-1:0] reload_reg;
    logic [ecs_pkg::SW-1:0] mask_reg;
    logic [ecs_pkg::SW-1:0] status_reg;
    logic armed_reg;
    logic [ecs_pkg::CW-1:0] pos_cnt_reg;
    logic [ecs_pkg::CW-1:0] sep_cnt_reg;
    ecs_pkg::ecs_sep_t sep_st_reg;
    logic [ecs_pkg::CW-1:0] fifo_mem [ecs_pkg::FDEPTH];
    logic [ecs_pkg::FAW-1:0] wptr_reg;
    logic [ecs_pkg::FAW-1:0] rptr_reg;
    logic [ecs_pkg::FAW:0] fcnt_reg;
    logic stm_valid_reg;
    logic [ecs_pkg::CW-1:0] stm_data_reg;
    logic irq_reg;
    logic [ecs_pkg::DW-1:0] rdata_reg;

    logic ctrl_wr;
    logic arm_wr;
    ecs_pkg::ecs_mode_t mode;
    ecs_pkg::ecs_dec_t dec;
    logic is_pos;
    logic is_sep;
    logic is_buf;
    logic cnt_ok;
    logic step_up;
    logic step_dn;
    logic step_en;
    logic reload_hit;
    logic a_lvl;
    logic b_lvl;
    logic smp_edge;
    logic aux_edge;
    logic gate_edge;
    logic src_edge;
    logic push_en;
    logic [ecs_pkg::CW-1:0] push_data;
    logic fifo_full;
    logic fifo_empty;
    logic push_ok;
    logic pop_en;
    logic stm_load;
    logic ovr_ev;
    logic [ecs_pkg::SW-1:0] st_ev;

    assign ctrl_wr = i_wr && (i_addr == ecs_pkg::REG_CTRL);
    assign arm_wr = ctrl_wr && i_wdata[ecs_pkg::CTL_ARM];
    assign mode = ecs_pkg::ecs_mode_t'(ctrl_reg[ecs_pkg::CTL_MODE +: 3]);
    assign dec = ecs_pkg::ecs_dec_t'(ctrl_reg[ecs_pkg::CTL_DEC +: 2]);
    assign is_pos = (mode == ecs_pkg::MODE_POS_DEMAND) || (mode == ecs_pkg::MODE_POS_BUF);
    assign is_sep = (mode == ecs_pkg::MODE_SEP_SINGLE) || (mode == ecs_pkg::MODE_SEP_IMPL)
        || (mode == ecs_pkg::MODE_SEP_SMP);
    assign is_buf = (mode == ecs_pkg::MODE_POS_BUF) || (mode == ecs_pkg::MODE_SEP_IMPL)
        || (mode == ecs_pkg::MODE_SEP_SMP);
    assign cnt_ok = armed_reg && is_pos && !ctrl_wr;
    assign a_lvl = lvl[ecs_pkg::IN_A];
    assign b_lvl = lvl[ecs_pkg::IN_B];
    // polarity selects, start and gate independent
    assign smp_edge = ctrl_reg[ecs_pkg::CTL_SMP_FALL] ? fall[ecs_pkg::IN_SMP] : rise[ecs_pkg::IN_SMP];
    assign aux_edge = ctrl_reg[ecs_pkg::CTL_AUX_FALL] ? fall[ecs_pkg::IN_AUX] : rise[ecs_pkg::IN_AUX];
    assign gate_edge = ctrl_reg[ecs_pkg::CTL_GATE_FALL] ? fall[ecs_pkg::IN_GATE]
        : rise[ecs_pkg::IN_GATE];
    assign src_edge = ctrl_reg[ecs_pkg::CTL_SRC_FALL] ? fall[ecs_pkg::IN_SRC] : rise[ecs_pkg::IN_SRC];

    // control, reload and mask registers
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ctrl_reg <= ecs_pkg::CTL_RST;
            reload_reg <= ecs_pkg::CNT_ZERO;
            mask_reg <= '0;
            armed_reg <= 1'b0;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                ecs_pkg::REG_CTRL:
                begin
                    ctrl_reg <= i_wdata[ecs_pkg::CTL_W-1:0];
                    armed_reg <= i_wdata[ecs_pkg::CTL_ARM];
                end
                ecs_pkg::REG_RELOAD: reload_reg <= i_wdata[ecs_pkg::CW-1:0];
                ecs_pkg::REG_MASK: mask_reg <= i_wdata[ecs_pkg::SW-1:0];
                default: ;
            endcase
        end
    end

    // quadrature and two-pulse decode
    always_comb
    begin
        unique case (dec)
            ecs_pkg::DEC_X1:
            begin
                step_up = rise[ecs_pkg::IN_A] & ~b_lvl;
                step_dn = fall[ecs_pkg::IN_A] & ~b_lvl;
            end
            ecs_pkg::DEC_X2:
            begin
                step_up = (rise[ecs_pkg::IN_A] & ~b_lvl) | (fall[ecs_pkg::IN_A] & b_lvl);
                step_dn = (rise[ecs_pkg::IN_A] & b_lvl) | (fall[ecs_pkg::IN_A] & ~b_lvl);
            end
            ecs_pkg::DEC_X4:
            begin
                step_up = (rise[ecs_pkg::IN_A] & ~b_lvl) | (fall[ecs_pkg::IN_A] & b_lvl)
                    | (rise[ecs_pkg::IN_B] & a_lvl) | (fall[ecs_pkg::IN_B] & ~a_lvl);
                step_dn = (rise[ecs_pkg::IN_A] & b_lvl) | (fall[ecs_pkg::IN_A] & ~b_lvl)
                    | (rise[ecs_pkg::IN_B] & ~a_lvl) | (fall[ecs_pkg::IN_B] & a_lvl);
            end
            ecs_pkg::DEC_TWO:
            begin
                step_up = rise[ecs_pkg::IN_A];
                step_dn = rise[ecs_pkg::IN_B];
            end
        endcase
    end

    // simultaneous up and down on two-pulse cancel out
    assign step_en = step_up ^ step_dn;
    assign reload_hit = ctrl_reg[ecs_pkg::CTL_ZEN] && lvl[ecs_pkg::IN_Z] && (dec != ecs_pkg::DEC_TWO)
        && ({a_lvl, b_lvl} == ctrl_reg[ecs_pkg::CTL_PHASE +: 2]);

    // position counter; arming clears it, captures never do
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pos_cnt_reg <= ecs_pkg::CNT_ZERO;
        else if (arm_wr)
            pos_cnt_reg <= ecs_pkg::CNT_ZERO;
        else if (cnt_ok)
        begin
            // the step wins; the phase still holds next cycle, so the reload follows one clock later
            if (step_en)
                pos_cnt_reg <= step_up ? pos_cnt_reg + ecs_pkg::CNT_ONE
                    : pos_cnt_reg - ecs_pkg::CNT_ONE;
            else if (reload_hit)
                pos_cnt_reg <= reload_reg;
        end
    end

    // edge-separation sequencer
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sep_st_reg <= ecs_pkg::SEP_IDLE;
            sep_cnt_reg <= ecs_pkg::CNT_ZERO;
        end
        else if (ctrl_wr)
        begin
            sep_st_reg <= (i_wdata[ecs_pkg::CTL_ARM]
                && (i_wdata[ecs_pkg::CTL_MODE +: 3] >= ecs_pkg::MODE_SEP_SINGLE)
                && (i_wdata[ecs_pkg::CTL_MODE +: 3] <= ecs_pkg::MODE_SEP_SMP))
                ? ecs_pkg::SEP_WAIT_START : ecs_pkg::SEP_IDLE;
            sep_cnt_reg <= ecs_pkg::CNT_ZERO;
        end
        else
        begin
            unique case (sep_st_reg)
                ecs_pkg::SEP_IDLE: ;
                ecs_pkg::SEP_WAIT_START:
                    if (aux_edge)
                    begin
                        sep_st_reg <= ecs_pkg::SEP_COUNT;
                        sep_cnt_reg <= ecs_pkg::CNT_ZERO;
                    end
                ecs_pkg::SEP_COUNT:
                    // further start edges are not looked at here
                    if (gate_edge)
                    begin
                        unique case (mode)
                            ecs_pkg::MODE_SEP_SINGLE: sep_st_reg <= ecs_pkg::SEP_DONE;
                            ecs_pkg::MODE_SEP_IMPL: sep_st_reg <= ecs_pkg::SEP_WAIT_GATE;
                            default: sep_st_reg <= ecs_pkg::SEP_HOLD;
                        endcase
                    end
                    else if (src_edge)
                        sep_cnt_reg <= sep_cnt_reg + ecs_pkg::CNT_ONE;
                ecs_pkg::SEP_HOLD:
                    if (smp_edge)
                        sep_st_reg <= ecs_pkg::SEP_WAIT_GATE;
                ecs_pkg::SEP_WAIT_GATE:
                    if (gate_edge)
                    begin
                        sep_st_reg <= ecs_pkg::SEP_COUNT;
                        sep_cnt_reg <= ecs_pkg::CNT_ZERO;
                    end
                ecs_pkg::SEP_DONE: ;
                default: sep_st_reg <= ecs_pkg::SEP_IDLE;
            endcase
        end
    end

    // fifo push sources are exclusive by mode
    always_comb
    begin
        push_en = 1'b0;
        push_data = sep_cnt_reg;
        if (armed_reg && (mode == ecs_pkg::MODE_POS_BUF) && smp_edge)
        begin
            push_en = 1'b1;
            push_data = pos_cnt_reg;
        end
        else if ((sep_st_reg == ecs_pkg::SEP_COUNT) && gate_edge && (mode != ecs_pkg::MODE_SEP_SMP))
            push_en = 1'b1;
        else if (is_sep && (sep_st_reg == ecs_pkg::SEP_HOLD) && smp_edge)
            push_en = 1'b1;
    end

    assign ovr_ev = armed_reg && (mode == ecs_pkg::MODE_SEP_SMP) && smp_edge
        && (sep_st_reg != ecs_pkg::SEP_HOLD);
    assign fifo_full = (fcnt_reg == ecs_pkg::FIFO_FULL);
    assign fifo_empty = (fcnt_reg == '0);
    // a full fifo drops the new value rather than stall the counters
    assign push_ok = push_en && !fifo_full;
    assign stm_load = is_buf && !fifo_empty && (!stm_valid_reg || i_stm_ready);
    assign pop_en = is_buf ? stm_load : (i_rd && (i_addr == ecs_pkg::REG_DATA) && !fifo_empty);

    // result fifo
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fcnt_reg <= '0;
        end
        else
        begin
            if (push_ok)
                wptr_reg <= wptr_reg + ecs_pkg::PTR_ONE;
            if (pop_en)
                rptr_reg <= rptr_reg + ecs_pkg::PTR_ONE;
            if (push_ok && !pop_en)
                fcnt_reg <= fcnt_reg + ecs_pkg::FIFO_ONE;
            else if (pop_en && !push_ok)
                fcnt_reg <= fcnt_reg - ecs_pkg::FIFO_ONE;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (push_ok)
            fifo_mem[wptr_reg] <= push_data;
    end

    // stream stage toward host memory
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            stm_valid_reg <= 1'b0;
            stm_data_reg <= ecs_pkg::CNT_ZERO;
        end
        else if (stm_load)
        begin
            stm_valid_reg <= 1'b1;
            stm_data_reg <= fifo_mem[rptr_reg];
        end
        else if (i_stm_ready)
            stm_valid_reg <= 1'b0;
    end

    // sticky status, cleared by reading it; a new event wins
    assign st_ev = {push_en && fifo_full, ovr_ev, push_ok};
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            status_reg <= ((i_rd && (i_addr == ecs_pkg::REG_STATUS)) ? '0 : status_reg) | st_ev;
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_reg <= '0;
        else if (i_rd)
        begin
            case (i_addr)
                ecs_pkg::REG_CTRL: rdata_reg <= ecs_pkg::DW'(ctrl_reg);
                ecs_pkg::REG_RELOAD: rdata_reg <= reload_reg;
                ecs_pkg::REG_COUNT: rdata_reg <= pos_cnt_reg;
                ecs_pkg::REG_DATA: rdata_reg <= fifo_empty ? '0 : fifo_mem[rptr_reg];
                ecs_pkg::REG_STATUS: rdata_reg <= ecs_pkg::DW'(status_reg);
                ecs_pkg::REG_MASK: rdata_reg <= ecs_pkg::DW'(mask_reg);
                ecs_pkg::REG_STATE: rdata_reg <= ecs_pkg::DW'({sep_st_reg, fcnt_reg, armed_reg});
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign o_rdata = rdata_reg;
    assign o_stm_valid = stm_valid_reg;
    assign o_stm_data = stm_data_reg;
    assign o_irq = irq_reg;

    a_hold_unarmed: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (!armed_reg && !ctrl_wr) |=> (pos_cnt_reg == $past(pos_cnt_reg)))
        else $error("count moved while unarmed");
    a_x1_step_up: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && dec == ecs_pkg::DEC_X1 && rise[ecs_pkg::IN_A] && !b_lvl)
        |=> (pos_cnt_reg == $past(pos_cnt_reg) + ecs_pkg::CNT_ONE))
        else $error("x1 increment missing");
    a_x2_fall_down: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && dec == ecs_pkg::DEC_X2 && fall[ecs_pkg::IN_A] && !b_lvl)
        |=> (pos_cnt_reg == $past(pos_cnt_reg) - ecs_pkg::CNT_ONE))
        else $error("x2 decrement missing");
    a_x4_b_edge: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && dec == ecs_pkg::DEC_X4 && rise[ecs_pkg::IN_B] && a_lvl)
        |=> (pos_cnt_reg == $past(pos_cnt_reg) + ecs_pkg::CNT_ONE))
        else $error("x4 b edge not counted");
    a_index_reload: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && reload_hit && !step_en) |=> (pos_cnt_reg == $past(reload_reg)))
        else $error("index reload missing");
    a_step_before_reload: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && reload_hit && step_en && step_up)
        |=> (pos_cnt_reg == $past(pos_cnt_reg) + ecs_pkg::CNT_ONE))
        else $error("reload overtook step");
    a_two_pulse_dn: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (cnt_ok && dec == ecs_pkg::DEC_TWO && rise[ecs_pkg::IN_B] && !rise[ecs_pkg::IN_A])
        |=> (pos_cnt_reg == $past(pos_cnt_reg) - ecs_pkg::CNT_ONE))
        else $error("two-pulse decrement missing");
    a_capture_count: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (armed_reg && mode == ecs_pkg::MODE_POS_BUF && smp_edge)
        |-> (push_en && push_data == pos_cnt_reg))
        else $error("sample capture wrong");
    a_sep_stop_push: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (!ctrl_wr && sep_st_reg == ecs_pkg::SEP_COUNT && gate_edge && mode == ecs_pkg::MODE_SEP_IMPL)
        |-> push_en ##1 (sep_st_reg == ecs_pkg::SEP_WAIT_GATE))
        else $error("gate edge did not store");
    a_single_done: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (sep_st_reg == ecs_pkg::SEP_DONE && !ctrl_wr) |=> (sep_st_reg == ecs_pkg::SEP_DONE)
        && $stable(sep_cnt_reg))
        else $error("single result disturbed");
    a_overrun_flag: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ovr_ev |=> status_reg[ecs_pkg::ST_OVR])
        else $error("overrun not flagged");
endmodule : ecs_counter

// >>> verification/ecs_pin_model.sv
/*
 * encoder, trigger and sample clock pin model on the pin lanes;
 * assumes one bench process calls its tasks on the system clock.
 */
`timescale 1ns/1ps
module ecs_pin_model (
    input wire logic i_sys_clk,
    output logic [ecs_pkg::NIN-1:0] o_pin
);
    initial o_pin = '0;
    // seven cycles per level: well past the sync and edge stages
    task automatic hold_set(input int lane, input logic v);
        begin
            @(posedge i_sys_clk);
            o_pin[lane] <= v;
            repeat (6) @(posedge i_sys_clk);
        end
    endtask : hold_set
    // one pin moves per phase, so no step is ever ambiguous
    task automatic quad(input int n, input bit rev);
        begin
            for (int i = 0; i < n * 4; i++)
            begin
                hold_set((i % 2 == 0) == rev ? ecs_pkg::IN_B : ecs_pkg::IN_A, i % 4 < 2);
            end
        end
    endtask : quad
    task automatic pulse(input int lane, input int n);
        begin
            for (int i = 0; i < n; i++)
            begin
                hold_set(lane, 1'b1);
                hold_set(lane, 1'b0);
            end
        end
    endtask : pulse
endmodule : ecs_pin_model

// >>> verification/ecs_counter_bench.sv
/*
 * self-checking bench of ecs_counter with random counts;
 * assumes ecs_pkg and ecs_pin_model are compiled first.
 */
`timescale 1ns/1ps
module ecs_counter_bench;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ecs_pkg::AW-1:0] addr = '0;
    logic [ecs_pkg::DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ready = 1'b0;
    logic [ecs_pkg::DW-1:0] rdata;
    logic [ecs_pkg::CW-1:0] sdata;
    logic valid;
    logic irq;
    logic [ecs_pkg::NIN-1:0] pin;
    logic [ecs_pkg::CW-1:0] strm[$];
    int seed = 54028;
    int num_errors = 0;
    int num_checks = 0;
    int n;
    int k;
    always #20 sys_clk = ~sys_clk;
    ecs_pin_model u_enc (.i_sys_clk(sys_clk), .o_pin(pin));
    ecs_counter u_dut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_enc_a(pin[ecs_pkg::IN_A]),
        .i_enc_b(pin[ecs_pkg::IN_B]), .i_enc_z(pin[ecs_pkg::IN_Z]),
        .i_gate(pin[ecs_pkg::IN_GATE]), .i_aux(pin[ecs_pkg::IN_AUX]),
        .i_src(pin[ecs_pkg::IN_SRC]), .i_smp(pin[ecs_pkg::IN_SMP]), .i_stm_ready(ready),
        .o_stm_valid(valid), .o_stm_data(sdata), .o_irq(irq));
    // random ready keeps the sink stalling now and then
    always @(posedge sys_clk)
    begin
        if (valid === 1'b1 && ready === 1'b1)
            strm.push_back(sdata);
        ready <= ($random(seed) & 1) != 0;
    end
    task automatic wrap_up;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        begin
            num_checks++;
            if (g !== e)
            begin
                num_errors++;
                $display("unexpected at %0t: got %h want %h", $time, g, e);
            end
        end
    endtask : chk
    task automatic wr_reg(input logic [ecs_pkg::AW-1:0] a, input logic [31:0] d);
        begin
            @(posedge sys_clk);
            wr <= 1'b1;
            addr <= a;
            wdata <= d;
            @(posedge sys_clk);
            wr <= 1'b0;
        end
    endtask : wr_reg
    task automatic rd_chk(input logic [ecs_pkg::AW-1:0] a, input logic [31:0] m,
        input logic [31:0] e);
        begin
            @(posedge sys_clk);
            rd <= 1'b1;
            addr <= a;
            @(posedge sys_clk);
            rd <= 1'b0;
            #1 chk(rdata & m, e);
        end
    endtask : rd_chk
    // flags start at the reload phase field; bit 0 always arms
    function automatic logic [31:0] ctl(input int mode, input int dec, input int flags);
        return 32'(1 + (mode << ecs_pkg::CTL_MODE) + (dec << ecs_pkg::CTL_DEC)
            + (flags << ecs_pkg::CTL_PHASE));
    endfunction : ctl
    task automatic wait_strm(input int cnt);
        begin
            for (int i = 0; i < 200 && strm.size() < cnt; i++)
                @(posedge sys_clk);
        end
    endtask : wait_strm
    initial
    begin
        #(40 * 40000);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        u_enc.quad(2, 1'b0);
        rd_chk(ecs_pkg::REG_COUNT, '1, 32'h0);
        rd_chk(3'h7, '1, 32'h0);
        for (int d = 0; d < 3; d++)
        begin
            n = ($random(seed) & 7) + 1;
            wr_reg(ecs_pkg::REG_CTRL, ctl(0, d, 0));
            u_enc.quad(n, 1'b0);
            rd_chk(ecs_pkg::REG_COUNT, '1, 32'(n << d));
            u_enc.quad(n, 1'b1);
            rd_chk(ecs_pkg::REG_COUNT, '1, 32'h0);
        end
        n = ($random(seed) & 3) + 2;
        wr_reg(ecs_pkg::REG_CTRL, ctl(0, 3, 0));
        u_enc.pulse(ecs_pkg::IN_A, n);
        u_enc.pulse(ecs_pkg::IN_B, 1);
        rd_chk(ecs_pkg::REG_COUNT, '1, 32'(n - 1));
        k = $random(seed);
        wr_reg(ecs_pkg::REG_RELOAD, k);
        wr_reg(ecs_pkg::REG_CTRL, ctl(0, 2, 4));
        u_enc.hold_set(ecs_pkg::IN_Z, 1'b1);
        u_enc.quad(1, 1'b0);
        u_enc.hold_set(ecs_pkg::IN_Z, 1'b0);
        rd_chk(ecs_pkg::REG_COUNT, '1, k);
        u_enc.quad(1, 1'b0);
        rd_chk(ecs_pkg::REG_COUNT, '1, 32'(k + 4));
        wr_reg(ecs_pkg::REG_CTRL, ctl(1, 0, ($random(seed) & 1) << 3));
        u_enc.quad(2, 1'b0);
        u_enc.pulse(ecs_pkg::IN_SMP, 1);
        u_enc.quad(3, 1'b0);
        u_enc.pulse(ecs_pkg::IN_SMP, 1);
        wait_strm(2);
        chk(strm[0], 32'h2);
        chk(strm[1], 32'h5);
        // clears the push flag left by the captures, so the irq check below means something
        rd_chk(ecs_pkg::REG_STATUS, 32'h1, 32'h1);
        wr_reg(ecs_pkg::REG_MASK, 32'h1);
        for (int r = 0; r < 2; r++)
        begin
            k = ($random(seed) & 3) + 1;
            n = $random(seed) & 7;
            wr_reg(ecs_pkg::REG_CTRL, ctl(2, 0, n << 4));
            u_enc.pulse(ecs_pkg::IN_SRC, 1);
            // this source pulse lies inside start high: counted only if start is rising-active
            u_enc.hold_set(ecs_pkg::IN_AUX, 1'b1);
            u_enc.pulse(ecs_pkg::IN_SRC, 1);
            u_enc.hold_set(ecs_pkg::IN_AUX, 1'b0);
            u_enc.pulse(ecs_pkg::IN_SRC, k);
            u_enc.pulse(ecs_pkg::IN_AUX, 1);
            u_enc.pulse(ecs_pkg::IN_GATE, 1);
            chk(32'(irq), 32'h1);
            rd_chk(ecs_pkg::REG_STATUS, 32'h1, 32'h1);
            u_enc.pulse(ecs_pkg::IN_AUX, 1);
            u_enc.pulse(ecs_pkg::IN_SRC, 2);
            u_enc.pulse(ecs_pkg::IN_GATE, 1);
            chk(32'(irq), 32'h0);
            rd_chk(ecs_pkg::REG_DATA, '1, 32'(k + ((n & 1) ^ 1)));
            rd_chk(ecs_pkg::REG_DATA, '1, 32'h0);
        end
        strm.delete();
        wr_reg(ecs_pkg::REG_CTRL, ctl(3, 0, 0));
        u_enc.pulse(ecs_pkg::IN_AUX, 1);
        u_enc.pulse(ecs_pkg::IN_SRC, 2);
        // first gate edge stores, the second one starts the next interval
        u_enc.pulse(ecs_pkg::IN_GATE, 2);
        u_enc.pulse(ecs_pkg::IN_SRC, 3);
        u_enc.pulse(ecs_pkg::IN_GATE, 1);
        wait_strm(2);
        chk(strm[0], 32'h2);
        chk(strm[1], 32'h3);
        strm.delete();
        wr_reg(ecs_pkg::REG_CTRL, ctl(4, 0, 0));
        u_enc.pulse(ecs_pkg::IN_SMP, 1);
        rd_chk(ecs_pkg::REG_STATUS, 32'h2, 32'h2);
        u_enc.pulse(ecs_pkg::IN_AUX, 1);
        u_enc.pulse(ecs_pkg::IN_SRC, 2);
        u_enc.pulse(ecs_pkg::IN_GATE, 1);
        chk(32'(strm.size()), 32'h0);
        u_enc.pulse(ecs_pkg::IN_SMP, 1);
        wait_strm(1);
        chk(strm[0], 32'h2);
        wrap_up();
    end
endmodule : ecs_counter_bench
